//--- inc/bor_power_up_timer_pkg.sv
// Constants of the brown-out reset and power-up timer block
//Contract
//R1 - Enabled brown-out and supply low longer than qualify time asserts reset.
//R2 - Brown-out reset holds while supply stays below threshold.
//R3 - Supply recovery starts the power-up timer when enabled; reset extended.
//R4 - Supply drop during timer re-enters brown-out and restarts timer later.
//R5 - Brown-out enable and power-up timer enable are independent.
//R6 - Detector output rearms power-on reset while supply is low.
//R7 - Brown-out status flag cleared on every brown-out and power-on reset.
//R8 - Firmware sets both flags after power-on; uses them to spot brown-out.
//R9 - Mode 01: software enable bit turns brown-out on or off.
//R10 - Other modes: software enable bit inert and reads zero.
//R11 - Trip level comes only from the threshold field, never software.
//R12 - Mode 10: brown-out off in Sleep, back on outside Sleep.
//R13 - Mode 11: brown-out always on.
//R14 - Mode 00: brown-out always off.
//R15 - Enable requests the reference; detection waits until it settles.
//R16 - Disabled before reference settles: no brown-out registered.
//R17 - Software can read a reference-stable status bit.
//R18 - Power-up timer is 11 bits of 32 us slow ticks, 2048 ticks.
//R19 - Core held in reset while the power-up timer counts.
//R20 - Timer disable bit low enables timer, high bypasses it.
//R21 - Power-on flag cleared only by power-on reset, set only by software.
//R22 - Below-threshold input qualified by a configurable cycle count.
package bor_power_up_timer_pkg;
    localparam int CLK_PERIOD_NS = 5;
    localparam int LF_TICK_NS = 32000;
    localparam int LF_TICK_CYCLES = LF_TICK_NS / CLK_PERIOD_NS;
    localparam int TIMER_BITS = 11;
    localparam int QUALIFY_CYCLES = 16;

    // Register word byte addresses
    localparam logic [3:0] RESET_CONTROL_STATUS_ADDR = 4'h0;
    localparam logic [3:0] VOLTAGE_REFERENCE_CONTROL_ADDR = 4'h4;
    localparam logic [3:0] RESET_STATE_ADDR = 4'h8;

    // Field positions
    localparam int SW_ENABLE_BIT = 6;
    localparam int POWER_ON_N_BIT = 1;
    localparam int BROWNOUT_N_BIT = 0;
    localparam int REF_STABLE_BIT = 7;

    localparam logic [1:0] MODE_OFF = 2'h0;
    localparam logic [1:0] MODE_SOFTWARE = 2'h1;
    localparam logic [1:0] MODE_NO_SLEEP = 2'h2;
    localparam logic [1:0] MODE_ALWAYS = 2'h3;

    typedef enum logic [1:0] {
        ST_POWER_ON,
        ST_BROWNOUT,
        ST_TIMER,
        ST_RUN
    } seq_state_type;
endpackage

//--- verilog/brownout_reset_power_up_timer.sv
// Brown-out reset controller with power-up timer and Avalon-MM registers
`timescale 1ns/10ps
`default_nettype none
module brownout_reset_power_up_timer
    import bor_power_up_timer_pkg::*;
#(
    parameter int LF_TICK_CYCLES_P = LF_TICK_CYCLES,
    parameter int QUALIFY_CYCLES_P = QUALIFY_CYCLES
) (
    // Clock and power-on reset
    input wire logic sys_clk,
    input wire logic rst,
    // Configuration word
    input wire logic [1:0] brownout_mode_select,
    input wire logic [1:0] brownout_threshold_select,
    input wire logic power_up_timer_disable_n,
    // Analog and operating mode
    input wire logic supply_below,
    input wire logic sleep_mode,
    input wire logic reference_settled,
    // Reset and reference outputs
    output logic core_reset_q,
    output logic brownout_reset_q,
    output logic por_rearm_q,
    output logic reference_enable_q,
    output logic [1:0] trip_level_q,
    // Avalon-MM slave
    input wire logic [3:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    output logic [31:0] readdata,
    output logic waitrequest
);
    seq_state_type state_q, state_d;
    logic sw_enable_q;
    logic power_on_n_q;
    logic brownout_n_q;
    logic ref_stable_q;
    logic [15:0] qual_q;
    logic [15:0] tick_cnt_q;
    logic [TIMER_BITS-1:0] timer_q;
    logic bor_enabled;
    logic bor_active;
    logic qualified;
    logic tick;
    logic timer_done;
    logic timer_start;
    logic access;
    logic wr_rcs;
    logic [31:0] rd_mux;

    // R9 R10 R12 R13 R14 mode decode
    function automatic logic mode_enable(input logic [1:0] mode,
                                         input logic sw, input logic slp);
        unique case (mode)
            MODE_OFF: mode_enable = 1'b0;
            MODE_SOFTWARE: mode_enable = sw;
            MODE_NO_SLEEP: mode_enable = ~slp;
            MODE_ALWAYS: mode_enable = 1'b1;
        endcase
    endfunction

    // R10 bit is inert outside mode 01
    wire logic sw_effective = sw_enable_q &
        (brownout_mode_select == MODE_SOFTWARE);
    assign bor_enabled = mode_enable(brownout_mode_select, sw_effective,
                                     sleep_mode);
    // R15 R16 detection only once reference settled
    assign bor_active = bor_enabled & reference_settled;
    // R22 qualify count
    assign qualified = bor_active & supply_below &
        (qual_q == 16'(QUALIFY_CYCLES_P - 1));
    assign tick = (tick_cnt_q == 16'(LF_TICK_CYCLES_P - 1));
    // R18 2048 ticks of the 11-bit counter
    assign timer_done = tick & (&timer_q);
    // R20 low bit enables the timer; R5 independent of brown-out
    assign timer_start = ~power_up_timer_disable_n;

    always_comb begin
        state_d = state_q;
        unique case (state_q)
            ST_POWER_ON: begin
                state_d = timer_start ? ST_TIMER : ST_RUN;
            end
            ST_BROWNOUT: begin
                // R2 R3 leave once supply recovers or detection is no longer active
                if (!(bor_active && supply_below)) begin
                    state_d = timer_start ? ST_TIMER : ST_RUN;
                end
            end
            ST_TIMER: begin
                if (timer_done) begin
                    state_d = ST_RUN;
                end
            end
            ST_RUN: ;
        endcase
        // R1 R4 qualified drop wins from any state except ST_POWER_ON
        if (qualified && state_q != ST_POWER_ON) begin
            state_d = ST_BROWNOUT;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            state_q <= ST_POWER_ON;
        end else begin
            state_q <= state_d;
        end
    end

    // R22 consecutive low cycles
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            qual_q <= 16'h0000;
        end else if (!(bor_active && supply_below) || qualified) begin
            qual_q <= 16'h0000;
        end else begin
            qual_q <= qual_q + 16'h0001;
        end
    end

    // Slow tick divider, restarted so every delay is a full count
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            tick_cnt_q <= 16'h0000;
        end else if (state_q != ST_TIMER || tick) begin
            tick_cnt_q <= 16'h0000;
        end else begin
            tick_cnt_q <= tick_cnt_q + 16'h0001;
        end
    end

    // R4 timer reinitialised outside counting
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            timer_q <= '0;
        end else if (state_q != ST_TIMER) begin
            timer_q <= '0;
        end else if (tick) begin
            timer_q <= timer_q + 1'b1;
        end
    end

    // R19 core held through brown-out and timer
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            core_reset_q <= 1'b1;
            brownout_reset_q <= 1'b0;
            por_rearm_q <= 1'b0;
            reference_enable_q <= 1'b0;
            trip_level_q <= 2'h0;
            ref_stable_q <= 1'b0;
        end else begin
            core_reset_q <= state_d != ST_RUN;
            brownout_reset_q <= state_d == ST_BROWNOUT;
            // R6 rearm while detector sees low supply
            por_rearm_q <= bor_active & supply_below;
            // R15 request the reference while enabled
            reference_enable_q <= bor_enabled;
            // R11 level only from configuration
            trip_level_q <= brownout_threshold_select;
            // R17 stable flag for software
            ref_stable_q <= reference_settled;
        end
    end

    // Bus: one wait cycle, then the access completes
    assign access = (read | write) & waitrequest;
    assign wr_rcs = write & ~waitrequest &
        (address == RESET_CONTROL_STATUS_ADDR);

    always_comb begin
        rd_mux = 32'h0000_0000;
        unique case (address)
            RESET_CONTROL_STATUS_ADDR: begin
                rd_mux[SW_ENABLE_BIT] = sw_effective;
                rd_mux[POWER_ON_N_BIT] = power_on_n_q;
                rd_mux[BROWNOUT_N_BIT] = brownout_n_q;
            end
            VOLTAGE_REFERENCE_CONTROL_ADDR: begin
                rd_mux[REF_STABLE_BIT] = ref_stable_q;
            end
            RESET_STATE_ADDR: begin
                rd_mux[1:0] = state_q;
                rd_mux[2] = core_reset_q;
            end
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            waitrequest <= 1'b1;
            readdata <= 32'h0000_0000;
        end else begin
            waitrequest <= ~access;
            if (access && read) begin
                readdata <= rd_mux;
            end
        end
    end

    // Status flags: hardware clear beats a software set
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            // R21 R7 power-on clears both flags
            power_on_n_q <= 1'b0;
            brownout_n_q <= 1'b0;
            sw_enable_q <= 1'b0;
        end else begin
            if (state_q == ST_POWER_ON) begin
                sw_enable_q <= brownout_mode_select == MODE_SOFTWARE;
            end else if (wr_rcs) begin
                sw_enable_q <= writedata[SW_ENABLE_BIT];
            end
            // R21 software may only set it
            if (wr_rcs && writedata[POWER_ON_N_BIT]) begin
                power_on_n_q <= 1'b1;
            end
            // R7 brown-out event clears the flag
            if (qualified) begin
                brownout_n_q <= 1'b0;
            end else if (wr_rcs) begin
                brownout_n_q <= writedata[BROWNOUT_N_BIT];
            end
        end
    end

    // Checks
    sequence s_low_run;
        bor_active && supply_below && state_q == ST_RUN;
    endsequence

    property p_bor_assert;
        @(posedge sys_clk) disable iff (rst)
        qualified |=> brownout_reset_q && core_reset_q;
    endproperty
    a_bor_assert: assert property (p_bor_assert) // R1
        else $error("brown-out reset missing after qualification");

    property p_bor_hold;
        @(posedge sys_clk) disable iff (rst)
        (state_q == ST_BROWNOUT && bor_active && supply_below)
        |=> state_q == ST_BROWNOUT;
    endproperty
    a_bor_hold: assert property (p_bor_hold) // R2
        else $error("brown-out reset released while supply low");

    property p_timer_after;
        @(posedge sys_clk) disable iff (rst)
        (state_q == ST_BROWNOUT && !supply_below && timer_start)
        |=> state_q == ST_TIMER && timer_q == '0;
    endproperty
    a_timer_after: assert property (p_timer_after) // R3
        else $error("power-up timer not started on recovery");

    property p_timer_restart;
        @(posedge sys_clk) disable iff (rst)
        (state_q == ST_TIMER && qualified) |=> state_q == ST_BROWNOUT
        ##1 timer_q == '0;
    endproperty
    a_timer_restart: assert property (p_timer_restart) // R4
        else $error("timer not reinitialised by brown-out");

    property p_qualify;
        @(posedge sys_clk) disable iff (rst)
        s_low_run ##0 (qual_q == 16'h0000)
        |-> !qualified [*3];
    endproperty
    a_qualify: assert property (p_qualify) // R22
        else $error("brown-out reset before qualify time");

    property p_off_mode;
        @(posedge sys_clk) disable iff (rst)
        brownout_mode_select == MODE_OFF |=> !reference_enable_q;
    endproperty
    a_off_mode: assert property (p_off_mode) // R14
        else $error("brown-out enabled in off mode");

    property p_sw_read;
        @(posedge sys_clk) disable iff (rst)
        (access && read && address == RESET_CONTROL_STATUS_ADDR &&
         brownout_mode_select != MODE_SOFTWARE)
        |=> !readdata[SW_ENABLE_BIT] && !waitrequest;
    endproperty
    a_sw_read: assert property (p_sw_read) // R10
        else $error("software enable read nonzero outside mode 01");

    property p_settle;
        @(posedge sys_clk) disable iff (rst)
        !reference_settled |=> !brownout_reset_q && !por_rearm_q;
    endproperty
    a_settle: assert property (p_settle) // R16
        else $error("brown-out sensed before reference settled");

    property p_flag_clear;
        @(posedge sys_clk) disable iff (rst)
        qualified |=> !brownout_n_q;
    endproperty
    a_flag_clear: assert property (p_flag_clear) // R7
        else $error("brown-out flag not cleared");

    property p_por_flag;
        @(posedge sys_clk) disable iff (rst)
        power_on_n_q |=> power_on_n_q;
    endproperty
    a_por_flag: assert property (p_por_flag) // R21
        else $error("power-on flag cleared without power-on reset");

    property p_sleep_mode;
        @(posedge sys_clk) disable iff (rst)
        (brownout_mode_select == MODE_NO_SLEEP)
        |=> reference_enable_q == !$past(sleep_mode);
    endproperty
    a_sleep_mode: assert property (p_sleep_mode) // R12
        else $error("sleep gating of brown-out wrong");

    property p_timer_hold;
        @(posedge sys_clk) disable iff (rst)
        state_q == ST_TIMER |-> core_reset_q && !brownout_reset_q;
    endproperty
    a_timer_hold: assert property (p_timer_hold) // R19
        else $error("core released while power-up timer counts");

    property p_timer_release;
        @(posedge sys_clk) disable iff (rst)
        (timer_done && !qualified) |=> state_q == ST_RUN && !core_reset_q;
    endproperty
    a_timer_release: assert property (p_timer_release) // R18
        else $error("core not released at end of power-up count");

    property p_sw_mode;
        @(posedge sys_clk) disable iff (rst)
        (brownout_mode_select == MODE_SOFTWARE)
        |=> reference_enable_q == $past(sw_enable_q);
    endproperty
    a_sw_mode: assert property (p_sw_mode) // R9
        else $error("software enable not followed in mode 01");

    property p_always_mode;
        @(posedge sys_clk) disable iff (rst)
        (brownout_mode_select == MODE_ALWAYS) |=> reference_enable_q;
    endproperty
    a_always_mode: assert property (p_always_mode) // R13
        else $error("brown-out disabled in always-on mode");

    property p_trip;
        @(posedge sys_clk) disable iff (rst)
        1'b1 |=> trip_level_q == $past(brownout_threshold_select);
    endproperty
    a_trip: assert property (p_trip) // R11
        else $error("trip level not taken from configuration");
endmodule
`default_nettype wire

//--- sim/tb.sv
// Self-checking bench for the brown-out reset and power-up timer block
`timescale 1ns/10ps
`default_nettype none
module tb;
    import bor_power_up_timer_pkg::*;
    localparam int TICK = 4;
    localparam int QUAL = 4;
    localparam int DELAY = 2048 * TICK;
    localparam int LIMIT = 30000;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic [1:0] mode = MODE_SOFTWARE;
    logic [1:0] thresh = 2'h2;
    logic timer_off_n = 1'b0;
    logic supply_below = 1'b0;
    logic sleep_mode = 1'b0;
    logic settled = 1'b1;
    logic core_reset, bor_reset, rearm, ref_en;
    logic [1:0] trip;
    logic [3:0] address = 4'h0;
    logic read = 1'b0;
    logic write = 1'b0;
    logic [31:0] writedata = 32'h0;
    logic [31:0] readdata, rd;
    logic waitrequest;
    int failures = 0;
    int samples_checked = 0;
    int cycles = 0;
    int n;

    brownout_reset_power_up_timer #(
        .LF_TICK_CYCLES_P(TICK),
        .QUALIFY_CYCLES_P(QUAL)
    ) uut (
        .sys_clk(sys_clk), .rst(rst),
        .brownout_mode_select(mode), .brownout_threshold_select(thresh),
        .power_up_timer_disable_n(timer_off_n),
        .supply_below(supply_below), .sleep_mode(sleep_mode),
        .reference_settled(settled),
        .core_reset_q(core_reset), .brownout_reset_q(bor_reset),
        .por_rearm_q(rearm), .reference_enable_q(ref_en),
        .trip_level_q(trip),
        .address(address), .read(read), .write(write),
        .writedata(writedata), .readdata(readdata),
        .waitrequest(waitrequest)
    );

    always #2.5 sys_clk = ~sys_clk;

    // Hang guard
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == LIMIT) begin
            failures++;
            report_and_stop();
        end
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp,
                         input string what);
        samples_checked++;
        if (got !== exp) begin
            failures++;
            $display("mismatch at %0t: %s got %h expected %h", $time, what,
                     got, exp);
        end
    endtask

    // Request held until waitrequest is sampled low
    task automatic bus_read(input logic [3:0] a, output logic [31:0] d);
        @(posedge sys_clk);
        address <= a;
        read <= 1'b1;
        do begin
            @(posedge sys_clk);
        end while (waitrequest !== 1'b0);
        d = readdata;
        read <= 1'b0;
    endtask

    task automatic bus_write(input logic [3:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        address <= a;
        writedata <= d;
        write <= 1'b1;
        do begin
            @(posedge sys_clk);
        end while (waitrequest !== 1'b0);
        write <= 1'b0;
    endtask

    task automatic read_check(input logic [3:0] a, input logic [31:0] exp);
        bus_read(a, rd);
        check(rd, exp, "register read");
    endtask

    task automatic wait_free(output int c);
        c = 0;
        while (core_reset !== 1'b0 && c < 20000) begin
            @(posedge sys_clk);
            c++;
        end
    endtask

    task automatic wait_bor_low();
        int k = 0;
        while (bor_reset !== 1'b0 && k < 20) begin
            @(posedge sys_clk);
            k++;
        end
    endtask

    // Supply dip of len cycles, then release; outputs watched each edge
    task automatic dip(input int len, input logic exp_bor,
                       input logic exp_rearm);
        logic sb = 1'b0;
        logic sr = 1'b0;
        @(posedge sys_clk);
        supply_below <= 1'b1;
        for (int i = 0; i < len + 3; i++) begin
            @(posedge sys_clk);
            if (i == len - 1) supply_below <= 1'b0;
            if (bor_reset === 1'b1) sb = 1'b1;
            if (rearm === 1'b1) sr = 1'b1;
        end
        check(32'(sb), 32'(exp_bor), "brown-out seen");
        check(32'(sr), 32'(exp_rearm), "rearm seen");
        wait_free(n);
    endtask

    task automatic end_test(input string name);
        $display("test %s done at %0t", name, $time);
    endtask

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    initial begin
        repeat (4) @(posedge sys_clk);
        rst <= 1'b0;
        wait_free(n);
        check(32'(n >= DELAY - 2 && n <= DELAY + 3), 1, "power-up");
        read_check(RESET_CONTROL_STATUS_ADDR, 32'h40);
        read_check(VOLTAGE_REFERENCE_CONTROL_ADDR, 32'h80);
        read_check(4'hc, 32'h0);
        read_check(RESET_STATE_ADDR, 32'h3);
        check(32'(trip), 32'(thresh), "trip level");
        bus_write(RESET_CONTROL_STATUS_ADDR, 32'h43);
        read_check(RESET_CONTROL_STATUS_ADDR, 32'h43);
        end_test("power_up");
        // Dip one cycle short of qualification
        dip(QUAL - 1, 1'b0, 1'b1);
        @(posedge sys_clk);
        supply_below <= 1'b1;
        repeat (20) @(posedge sys_clk);
        check(32'({bor_reset, core_reset}), 32'h3, "held");
        read_check(RESET_STATE_ADDR, 32'h5);
        read_check(RESET_CONTROL_STATUS_ADDR, 32'h42);
        supply_below <= 1'b0;
        wait_bor_low();
        repeat (1000) @(posedge sys_clk);
        check(32'(core_reset), 1, "timer hold");
        supply_below <= 1'b1;
        repeat (10) @(posedge sys_clk);
        check(32'(bor_reset), 1, "re-entry");
        supply_below <= 1'b0;
        wait_bor_low();
        wait_free(n);
        check(32'(n >= DELAY - 2 && n <= DELAY + 3), 1, "restart");
        end_test("timer_restart");
        timer_off_n <= 1'b1;
        dip(10, 1'b1, 1'b1);
        check(32'(n <= 2), 1, "bypass");
        bus_write(RESET_CONTROL_STATUS_ADDR, 32'h03);
        read_check(RESET_CONTROL_STATUS_ADDR, 32'h03);
        check(32'(ref_en), 0, "reference off");
        dip(10, 1'b0, 1'b0);
        bus_write(RESET_CONTROL_STATUS_ADDR, 32'h43);
        dip(10, 1'b1, 1'b1);
        end_test("software_mode");
        mode <= MODE_OFF;
        bus_write(RESET_CONTROL_STATUS_ADDR, 32'h43);
        read_check(RESET_CONTROL_STATUS_ADDR, 32'h03);
        dip(10, 1'b0, 1'b0);
        mode <= MODE_NO_SLEEP;
        sleep_mode <= 1'b1;
        dip(10, 1'b0, 1'b0);
        sleep_mode <= 1'b0;
        dip(10, 1'b1, 1'b1);
        mode <= MODE_ALWAYS;
        sleep_mode <= 1'b1;
        dip(10, 1'b1, 1'b1);
        read_check(RESET_CONTROL_STATUS_ADDR, 32'h02);
        end_test("modes");
        settled <= 1'b0;
        read_check(VOLTAGE_REFERENCE_CONTROL_ADDR, 32'h0);
        check(32'(ref_en), 1, "reference request");
        dip(10, 1'b0, 1'b0);
        settled <= 1'b1;
        thresh <= 2'h1;
        bus_write(RESET_CONTROL_STATUS_ADDR, 32'hffffffff);
        repeat (2) @(posedge sys_clk);
        check(32'(trip), 32'h1, "trip after write");
        end_test("reference_and_level");
        // Mid-run power-on reset clears both flags again
        rst <= 1'b1;
        repeat (2) @(posedge sys_clk);
        rst <= 1'b0;
        wait_free(n);
        check(32'(n <= 2), 1, "reset bypass");
        read_check(RESET_CONTROL_STATUS_ADDR, 32'h0);
        end_test("mid_run_reset");
        report_and_stop();
    end
endmodule
`default_nettype wire
